// *** tss_defines.vh ***
// Purpose: shared constants for the tdm stream rate switch
// Assumes: 16-bit word-addressed register port
// Notes: rate codes select 2.048/4.096/8.192/16.384 Mbps
`ifndef TSS_DEFINES_VH
`define TSS_DEFINES_VH
`define TSS_ADDR_CTRL 16'h0000
`define TSS_ADDR_STATUS 16'h0001
`define TSS_RATE_WIN 9'h002
`define TSS_CM_FLAG 15
`define TSS_CTRL_BP_FAST 0
`define TSS_CTRL_LOC_FAST 1
`define TSS_CTRL_RESET 2'h0
`define TSS_RATE_RESET 2'h0
`define TSS_RATE_2M 2'h0
`define TSS_RATE_4M 2'h1
`define TSS_RATE_8M 2'h2
`define TSS_RATE_16M 2'h3
`define TSS_CM_SRC_BIT 14
`define TSS_FAST_STREAMS 16
`define TSS_STREAMS 32
`define TSS_IDLE_BIT 1'b1
`define TSS_LAST_PAGE 2'h2
`endif

// *** tss_link_timing.v ***
// Purpose: synchronise master clock, frame pulse and input streams; slot counter
// Assumes: master clock at most a quarter of mclk; active edge is falling
// Notes: one tick per active edge, a tick being one 32.768 Mbps bit slot
`timescale 1ns/10ps
`include "tss_defines.vh"
module tss_link_timing (
  input wire mclk,
  input wire rst,
  input wire masterClockIn,
  input wire masterFramePulseInN,
  input wire [63:0] inStreams,
  output reg tick_r,
  output reg [11:0] tickCnt_r,
  output reg [1:0] wrPage_r,
  output reg [1:0] rdPage_r,
  output reg [63:0] inBits_r
);
  reg clkS1_r;
  reg clkS2_r;
  reg clkS3_r;
  reg fpS1_r;
  reg fpS2_r;
  reg [63:0] dS1_r;
  reg [63:0] dS2_r;
  wire activeEdge;
  wire [1:0] page_nxt;

  // pulse and data take two stages, the depth at which the three-stage clock chain shows its edge, so they stay aligned
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      clkS1_r <= 1'b0;
      clkS2_r <= 1'b0;
      clkS3_r <= 1'b0;
      fpS1_r <= 1'b1;
      fpS2_r <= 1'b1;
      dS1_r <= 64'h0;
      dS2_r <= 64'h0;
    end else begin
      clkS1_r <= masterClockIn;
      clkS2_r <= clkS1_r;
      clkS3_r <= clkS2_r;
      fpS1_r <= masterFramePulseInN;
      fpS2_r <= fpS1_r;
      dS1_r <= inStreams;
      dS2_r <= dS1_r;
    end
  end

  assign activeEdge = clkS3_r & ~clkS2_r;
  assign page_nxt = (wrPage_r == `TSS_LAST_PAGE) ? 2'h0 : wrPage_r + 2'h1;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_r <= 1'b0;
      tickCnt_r <= 12'h000;
      wrPage_r <= 2'h0;
      rdPage_r <= 2'h1;
      inBits_r <= 64'h0;
    end else begin
      tick_r <= activeEdge;
      if (activeEdge) begin
        inBits_r <= dS2_r;
        if (!fpS2_r) begin
          // pulse low at the active edge marks slot 0 of a new frame
          tickCnt_r <= 12'h000;
          wrPage_r <= page_nxt;
          // read page trails write page by two frames
          rdPage_r <= (page_nxt == `TSS_LAST_PAGE) ? 2'h0 : page_nxt + 2'h1;
        end else begin
          tickCnt_r <= tickCnt_r + 12'h001;
        end
      end
    end
  end
endmodule // tss_link_timing

// *** tss_stream_switch.v ***
// Purpose: two-port tdm switch with per-stream rates and fast mode
// Assumes: frame pulse every 4096 active edges; unused fast-mode inputs tied
// Notes: data memory has three frame pages so delay is fixed at two frames
// Behaviour
// - each port has 32 in, 32 out streams
// - combined: 64 by 64 streams, 16384 channels
// - any output may take either port's input
// - local outputs routed by local connection memory
// - backplane outputs routed by backplane connection memory
// - all four paths work at once
// - per-input-stream rate register, four rates
// - per-output-stream rate register, four rates
// - backplane fast mode ignores backplane rate registers
// - local fast mode ignores local rate registers
// - local fast: streams 0-15 32.768, rest unused
// - backplane fast: streams 0-15 32.768, rest unused
// - fast streams carry 512 channels per frame
// - port modes independent of each other
// - local fast bit resets low
// - local inputs sampled aligned to frame pulse, clock
// - any input rate switchable to any output rate
// - fast to normal conversion keeps full capacity
// - source select bit picks local or backplane data
// - frame N input leaves in frame N+2
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "tss_defines.vh"
module tss_stream_switch (
  input wire mclk,
  input wire rst,
  input wire [15:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData_r,
  input wire masterClockIn,
  input wire masterFramePulseInN,
  input wire [31:0] backplaneInStreams,
  input wire [31:0] localInStreams,
  output wire [31:0] backplaneOutStreams,
  output wire [31:0] localOutStreams
);
  // stream index g: bit 5 is the port (0 backplane, 1 local), bits 4:0 the stream
  reg [1:0] ctrl_r;
  reg [1:0] inRate_r [0:63];
  reg [1:0] outRate_r [0:63];
  // connection memory, index {port, stream, channel}: {src, srcStream, srcChannel}
  reg [14:0] connMem [0:32767];
  // data memory, index {port, page, stream, channel}
  reg [7:0] dataMem [0:114687];
  reg [14:0] cmRdData_r;
  reg cmRdSel_r;
  reg [15:0] regRdMux_r;
  wire tick;
  wire [11:0] tickCnt;
  wire [1:0] wrPage;
  wire [1:0] rdPage;
  wire [63:0] inBits;
  wire [63:0] inWrEn;
  wire [64*17-1:0] inIdxFlat;
  wire [64*8-1:0] inByteFlat;
  wire [63:0] outBits;
  wire isRateWin;
  wire [5:0] rateIdx;
  integer i;
  integer j;

  // rate shift: how many slot bits one stream bit spans, as a power of two
  function [2:0] rateShift;
    input fast;
    input [1:0] code;
    begin
      if (fast) begin
        rateShift = 3'h0;
      end else begin
        case (code)
          `TSS_RATE_2M: rateShift = 3'h4;
          `TSS_RATE_4M: rateShift = 3'h3;
          `TSS_RATE_8M: rateShift = 3'h2;
          default: rateShift = 3'h1;
        endcase
      end
    end
  endfunction

  function [11:0] shiftMask;
    input [2:0] k;
    begin
      case (k)
        3'h0: shiftMask = 12'h000;
        3'h1: shiftMask = 12'h001;
        3'h2: shiftMask = 12'h003;
        3'h3: shiftMask = 12'h007;
        default: shiftMask = 12'h00F;
      endcase
    end
  endfunction

  tss_link_timing uLink (
    .mclk(mclk),
    .rst(rst),
    .masterClockIn(masterClockIn),
    .masterFramePulseInN(masterFramePulseInN),
    .inStreams({localInStreams, backplaneInStreams}),
    .tick_r(tick),
    .tickCnt_r(tickCnt),
    .wrPage_r(wrPage),
    .rdPage_r(rdPage),
    .inBits_r(inBits)
  );

  assign backplaneOutStreams = outBits[31:0];
  assign localOutStreams = outBits[63:32];

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : gStream
      localparam [5:0] GI = g;
      wire fast;
      wire active;
      wire [2:0] inK;
      wire [11:0] inMask;
      wire [11:0] inBitIdx;
      wire inSample;
      wire [2:0] outK;
      wire [11:0] outMask;
      wire [11:0] outBitIdx;
      wire outSlot;
      wire outLoad;
      wire [14:0] entry;
      wire [7:0] srcByte;
      reg [6:0] inSh_r;
      reg [7:0] outSh_r;
      reg outBit_r;

      // each port reads only its own fast bit
      assign fast = GI[5] ? ctrl_r[`TSS_CTRL_LOC_FAST] : ctrl_r[`TSS_CTRL_BP_FAST];
      // upper sixteen streams idle while their port runs fast
      assign active = ~fast | (GI[4:0] < `TSS_FAST_STREAMS);
      // fast mode forces one bit per slot regardless of the rate register
      assign inK = rateShift(fast, inRate_r[g]);
      assign inMask = shiftMask(inK);
      assign inBitIdx = tickCnt >> inK;
      // sample on the last slot of each stream bit
      assign inSample = tick & active & ((tickCnt & inMask) == inMask);
      assign inWrEn[g] = inSample & (inBitIdx[2:0] == 3'h7);
      assign inByteFlat[g*8 +: 8] = {inSh_r, inBits[g]};
      assign inIdxFlat[g*17 +: 17] = {GI[5], wrPage, GI[4:0], inBitIdx[11:3]};

      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          inSh_r <= 7'h00;
        end else if (inSample) begin
          inSh_r <= {inSh_r[5:0], inBits[g]};
        end
      end

      assign outK = rateShift(fast, outRate_r[g]);
      assign outMask = shiftMask(outK);
      assign outBitIdx = tickCnt >> outK;
      assign outSlot = tick & active & ((tickCnt & outMask) == 12'h000);
      assign outLoad = outSlot & (outBitIdx[2:0] == 3'h0);
      // own port's connection memory only decides this output
      assign entry = connMem[{GI, outBitIdx[11:3]}];
      // source port bit, then source stream and channel at any rate
      assign srcByte = dataMem[{entry[`TSS_CM_SRC_BIT], rdPage, entry[13:0]}];

      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          outSh_r <= 8'h00;
          outBit_r <= `TSS_IDLE_BIT;
        end else if (tick && !active) begin
          // idling starts at the next slot tick, so a mode write can cut a multi-slot bit short
          outSh_r <= 8'h00;
          outBit_r <= `TSS_IDLE_BIT;
        end else if (outLoad) begin
          outSh_r <= {srcByte[6:0], 1'b0};
          outBit_r <= srcByte[7];
        end else if (outSlot) begin
          outSh_r <= {outSh_r[6:0], 1'b0};
          outBit_r <= outSh_r[7];
        end
      end
      assign outBits[g] = outBit_r;
    end
  endgenerate

  // all 64 input streams may complete a byte in one cycle; the array takes
  // every write, so no path waits on another
  always @(posedge mclk) begin
    for (j = 0; j < 64; j = j + 1) begin
      if (inWrEn[j]) begin
        dataMem[inIdxFlat[j*17 +: 17]] <= inByteFlat[j*8 +: 8];
      end
    end
  end

  assign isRateWin = (regAddr[15:7] == `TSS_RATE_WIN);
  assign rateIdx = {regAddr[6], regAddr[4:0]};

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `TSS_CTRL_RESET;
      for (i = 0; i < 64; i = i + 1) begin
        inRate_r[i] <= `TSS_RATE_RESET;
        outRate_r[i] <= `TSS_RATE_RESET;
      end
    end else if (regWr) begin
      if (regAddr == `TSS_ADDR_CTRL) begin
        ctrl_r <= regWrData[1:0];
      end else if (isRateWin && !regAddr[5]) begin
        inRate_r[rateIdx] <= regWrData[1:0];
      end else if (isRateWin && regAddr[5]) begin
        outRate_r[rateIdx] <= regWrData[1:0];
      end
    end
  end

  // connection memory has no reset; software must load it before use
  always @(posedge mclk) begin
    if (regWr && regAddr[`TSS_CM_FLAG]) begin
      connMem[regAddr[14:0]] <= regWrData[14:0];
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmRdData_r <= 15'h0000;
      cmRdSel_r <= 1'b0;
      regRdMux_r <= 16'h0000;
    end else begin
      cmRdSel_r <= regRd & regAddr[`TSS_CM_FLAG];
      if (regRd && regAddr[`TSS_CM_FLAG]) begin
        cmRdData_r <= connMem[regAddr[14:0]];
      end
      if (!regRd) begin
        regRdMux_r <= 16'h0000;
      end else if (regAddr == `TSS_ADDR_CTRL) begin
        regRdMux_r <= {14'h0000, ctrl_r};
      end else if (regAddr == `TSS_ADDR_STATUS) begin
        regRdMux_r <= {2'h0, wrPage, tickCnt};
      end else if (isRateWin && !regAddr[5]) begin
        regRdMux_r <= {14'h0000, inRate_r[rateIdx]};
      end else if (isRateWin && regAddr[5]) begin
        regRdMux_r <= {14'h0000, outRate_r[rateIdx]};
      end else begin
        regRdMux_r <= 16'h0000;
      end
    end
  end

  always @* begin
    if (cmRdSel_r) begin
      regRdData_r = {1'b0, cmRdData_r};
    end else begin
      regRdData_r = regRdMux_r;
    end
  end
endmodule // tss_stream_switch

// *** tss_framer_model.sv ***
// Purpose: framer driving master clock, frame pulse and both input stream sets
// Assumes: frames of FSLOTS slots, far shorter than real frames, keep runs brief
// Notes: data moves on the rising edge, half a slot before the active edge
`timescale 1ns/10ps
module tss_framer_model #(
  parameter int FSLOTS = 256
) (
  output logic mc,
  output logic fpN,
  output logic [31:0] bpIn,
  output logic [31:0] locIn,
  input logic [2:0] bpK,
  input logic [2:0] locK,
  output int slot,
  output int frame
);
  function automatic logic [7:0] byt(input int p, input int s, input int c, input int f);
    return 8'(c * 5 + s * 17 + f * 99 + p * 61);
  endfunction
  function automatic logic lvl(input int p, input int s, input int k);
    logic [7:0] b;
    if (k == 0 && s > 15) return 1'b1;
    b = byt(p, s, slot >> (k + 3), frame);
    return b[7 - ((slot >> k) & 7)];
  endfunction
  initial begin
    mc = 1'b1;
    fpN = 1'b1;
    bpIn = '1;
    locIn = '1;
    slot = FSLOTS - 1;
    frame = -1;
    forever begin
      #100 mc = 1'b0;
      #100 mc = 1'b1;
      slot = (slot + 1) % FSLOTS;
      frame = frame + (slot == 0);
      fpN = (slot != 0);
      for (int s = 0; s < 32; s++) begin
        bpIn[s] = lvl(0, s, bpK);
        locIn[s] = lvl(1, s, locK);
      end
    end
  end
endmodule // tss_framer_model

// *** tss_stream_switch_assertions.sv ***
// Purpose: port checks for the stream switch
// Assumes: fast mode changes only by control writes
// Notes: idle check waits longer than the slowest bit period
`timescale 1ns/10ps
`include "tss_defines.vh"
module tss_stream_switch_assertions (
  input logic mclk,
  input logic rst,
  input logic [15:0] regAddr,
  input logic [15:0] regWrData,
  input logic regWr,
  input logic regRd,
  input logic [15:0] regRdData_r,
  input logic masterClockIn,
  input logic [31:0] backplaneOutStreams,
  input logic [31:0] localOutStreams
);
  logic [1:0] fast_r;
  logic ctlSeen_r;
  logic mcDly_r;
  logic [7:0] age_r;
  logic [2:0] since_r;
  wire ctlWr = regWr && regAddr == `TSS_ADDR_CTRL;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fast_r <= 2'h0;
      ctlSeen_r <= 1'b0;
      age_r <= 8'h00;
      mcDly_r <= 1'b1;
      since_r <= 3'h7;
    end else begin
      mcDly_r <= masterClockIn;
      since_r <= (mcDly_r && !masterClockIn) ? 3'h0 : since_r + 3'(since_r != 3'h7);
      fast_r <= ctlWr ? regWrData[1:0] : fast_r;
      ctlSeen_r <= ctlSeen_r | ctlWr;
      age_r <= ctlWr ? 8'h00 : age_r + 8'(age_r != 8'hFF);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rdIdle;
    !regRd |=> regRdData_r == 16'h0000;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("stray read data");
  property p_ctlRst;
    regRd && regAddr == `TSS_ADDR_CTRL && !ctlSeen_r |=> regRdData_r == 16'h0000;
  endproperty
  a_ctlRst: assert property (p_ctlRst) else $error("control not cleared");
  property p_ctlRb;
    ctlWr ##1 regRd && regAddr == `TSS_ADDR_CTRL |=>
      regRdData_r[1:0] == $past(regWrData[1:0], 2);
  endproperty
  a_ctlRb: assert property (p_ctlRb) else $error("control readback");
  property p_rateRb;
    regWr && regAddr[15:7] == `TSS_RATE_WIN ##1 regRd && $stable(regAddr) |=>
      regRdData_r[1:0] == $past(regWrData[1:0], 2);
  endproperty
  a_rateRb: assert property (p_rateRb) else $error("rate readback");
  property p_locIdle;
    fast_r[1] && age_r == 8'hFF |-> &localOutStreams[31:16];
  endproperty
  a_locIdle: assert property (p_locIdle) else $error("local upper streams driven");
  property p_bpIdle;
    fast_r[0] && age_r == 8'hFF |-> &backplaneOutStreams[31:16];
  endproperty
  a_bpIdle: assert property (p_bpIdle) else $error("backplane upper streams driven");
  property p_locAlign;
    $changed(localOutStreams) |-> since_r inside {[2:6]};
  endproperty
  a_locAlign: assert property (p_locAlign) else $error("local output off edge");
  property p_bpAlign;
    $changed(backplaneOutStreams) |-> since_r inside {[2:6]};
  endproperty
  a_bpAlign: assert property (p_bpAlign) else $error("backplane output off edge");
endmodule // tss_stream_switch_assertions
bind tss_stream_switch tss_stream_switch_assertions tss_stream_switch_assertions_i (
  .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData_r(regRdData_r), .masterClockIn(masterClockIn),
  .backplaneOutStreams(backplaneOutStreams), .localOutStreams(localOutStreams));

// *** tss_stream_switch_tb_top.sv ***
// Purpose: self-checking bench for the stream switch
// Assumes: framer model makes the link timing
// Notes: reads and switched bytes are checked off queues
`timescale 1ns/10ps
`include "tss_defines.vh"
module tss_stream_switch_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic rdPend = 1'b0;
  logic [2:0] bpK = 3'h1;
  logic [2:0] locK = 3'h1;
  logic [31:0] seed = 32'h00000044;
  wire [15:0] regRdData_r;
  wire mc, fpN;
  wire [31:0] bpIn, locIn, bpOut, locOut;
  int slot, frame;
  int mismatches = 0;
  int checks = 0;
  logic [15:0] rdQ[$];
  logic [15:0] expQ[4][$];
  logic [7:0] sh[4];
  // route: out port, stream, channel, then source port, stream, channel; port 1 is local
  int rt[4][6] = '{'{1, 2, 1, 0, 1, 0}, '{0, 0, 0, 1, 4, 1}, '{0, 5, 1, 0, 2, 1}, '{1, 3, 0, 1, 6, 0}};
  // mode: control, then log2 slots per bit for backplane and local
  // the last mode pairs a fast port with a 16.384 port
  int md[6][3] = '{'{0, 1, 1}, '{1, 0, 4}, '{2, 2, 0}, '{3, 0, 0}, '{0, 3, 1}, '{1, 0, 1}};
  always #12.5 mclk = ~mclk;
  tss_stream_switch tss_stream_switch_i (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_r(regRdData_r),
    .masterClockIn(mc), .masterFramePulseInN(fpN), .backplaneInStreams(bpIn),
    .localInStreams(locIn), .backplaneOutStreams(bpOut), .localOutStreams(locOut));
  tss_framer_model tss_framer_model_i (.mc(mc), .fpN(fpN), .bpIn(bpIn), .locIn(locIn),
    .bpK(bpK), .locK(locK), .slot(slot), .frame(frame));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic finish_test();
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic cmpReg(input logic [15:0] e);
    chk(regRdData_r === e, "register read");
  endtask
  task automatic cmpByte(input logic [7:0] g, input logic [15:0] e);
    chk(g === e[7:0], "switched byte");
  endtask
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    rdQ.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask
  always @(posedge mclk) begin
    if (rdPend) cmpReg(rdQ.pop_front());
    rdPend <= regRd;
  end
  // a bit is taken at the active edge that starts the next bit, before the output moves
  always @(negedge mc) begin
    int k, ps;
    ps = (slot + 255) % 256;
    for (int t = 0; t < 4; t++) begin
      k = rt[t][0] ? locK : bpK;
      if ((slot & ((1 << k) - 1)) == 0) begin
        sh[t] = {sh[t][6:0], rt[t][0] ? locOut[rt[t][1]] : bpOut[rt[t][1]]};
        if ((ps >> k) % 8 == 7 && (ps >> (k + 3)) == rt[t][2] && expQ[t].size() > 0
            && expQ[t][0][15:8] == 8'(frame - (slot == 0)))
          cmpByte(sh[t], expQ[t].pop_front());
      end
    end
  end
  initial begin
    int f, k;
    logic [15:0] d;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`TSS_ADDR_CTRL, 16'h0000);
    rd(16'h0170, 16'h0000);
    rd(16'h0050, 16'h0000);
    bus(1'b0, 1'b0, 16'h0000, 16'h0000);
    while (frame < 1) @(posedge mclk);
    for (int m = 0; m < 6; m++) begin
      bpK <= 3'(md[m][1]);
      locK <= 3'(md[m][2]);
      bus(1'b1, 1'b0, `TSS_ADDR_CTRL, 16'(md[m][0]));
      rd(`TSS_ADDR_CTRL, 16'(md[m][0]));
      for (int a = 256; a < 384; a++) begin
        k = a[6] ? md[m][2] : md[m][1];
        d = (k == 0) ? 16'(rnd() & 3) : 16'(4 - k);
        bus(1'b1, 1'b0, 16'(a), d);
        rd(16'(a), d);
      end
      for (int t = 0; t < 4; t++)
        bus(1'b1, 1'b0, 16'h8000 | 16'(rt[t][0] << 14 | rt[t][1] << 9 | rt[t][2]),
          16'(rt[t][3] << 14 | rt[t][4] << 9 | rt[t][5]));
      bus(1'b0, 1'b0, 16'h0000, 16'h0000);
      f = frame + 1;
      for (int t = 0; t < 4; t++)
        for (int fo = f + 2; fo < f + 4; fo++)
          expQ[t].push_back({8'(fo),
            tss_framer_model_i.byt(rt[t][3], rt[t][4], rt[t][5], fo - 2)});
      while (frame < f + 4 || slot < 8) @(posedge mclk);
      for (int t = 0; t < 4; t++) chk(expQ[t].size() == 0, "byte missing");
    end
    finish_test();
  end
  // six modes of at most six short frames each, with slack
  initial begin
    #2200000;
    mismatches++;
    finish_test();
  end
endmodule // tss_stream_switch_tb_top
